// ==== sct_core.sv ====
// Purpose: guard timing, waiting-time counter and card activation control
// Assumes: card clock arrives as a plain input and is sampled by pclk
// Notes: one pclk domain; etu ticks are one-cycle enables
`timescale 1ns/1ps

// How it works
// RULE_01: software loads guard times after reset
// RULE_02: keep 12 and 22 etu character spacing
// RULE_03: software reloads block guard on etu change
// RULE_04: 32-bit waiting counter, one step per etu
// RULE_05: expiry flags timeout and locks the interface
// RULE_06: mode bit selects manual or automatic loading
// RULE_07: manual enable edges start and stop counting
// RULE_08: byte 2 write captures full hold value
// RULE_09: software restarts after manual timeout
// RULE_10: software adds margin above two etus
// RULE_11: automatic mode reloads at each start bit
// RULE_12: no character within count plus one locks
// RULE_13: software stages block then character wait
// RULE_14: software programs t0 work waiting time
// RULE_15: card keeps character wait within limit
// RULE_16: card keeps block wait within limit
// RULE_17: supply only with card present
// RULE_18: cold reset order and answer window
// RULE_19: warm reset low over 400 clocks
// RULE_20: hardware deactivates on extraction or supply loss
// RULE_21: guard counter runs from one to target
// RULE_22: block guard shadow taken on enable rise
module sct_core
	import sct_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// card side inputs
	input wire logic card_clk_in,
	input wire logic card_present,
	input wire logic supply_fail,
	input wire logic io_in,
	// character shifter
	input wire sct_pkg::sct_shift_type shift,
	output logic tx_permit,
	output logic rx_enable,
	output logic rx_io,
	output logic wt_timeout,
	// card contacts
	output sct_pkg::sct_pins_type card
);
	import sct_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [3:0] async_in;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic clk_prev_q;
	assign async_in = {io_in, supply_fail, card_present, card_clk_in};

	// two flops per pin input
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
				end
				else
				begin
					s1_q[gi] <= async_in[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate

	logic present;
	logic power_lost;
	logic card_edge;
	assign present = s2_q[1];
	assign power_lost = s2_q[2];
	assign rx_io = s2_q[3];

	////////////////////////////////////////////////////////////////////////////////
	// apb register file
	logic [8:0] gt_q, gt_d;
	logic bge_q, bge_d;
	logic [1:0] ctrl_q, ctrl_d;
	logic [2:0] card_sw_q, card_sw_d;
	logic [31:0] wt_q, wt_d;
	logic [31:0] hold_q, hold_d;
	logic [10:0] etu_div_q, etu_div_d;
	logic [2:0] sticky_q, sticky_d;
	logic [2:0] sticky_set;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic locked_q;
	logic [15:0] rst_low_q;
	logic [15:0] atr_cnt_q;
	sct_deact_type da_q;

	// true when the word address hits a register
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a[1:0] == 2'b00) && (a <= OFS_STATUS);
	endfunction

	logic wr;
	assign wr = psel && penable && pready_q && pwrite;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// next register values; one wait state, read data registered
	always_comb
	begin
		gt_d = gt_q;
		bge_d = bge_q;
		ctrl_d = ctrl_q;
		card_sw_d = card_sw_q;
		wt_d = wt_q;
		hold_d = hold_q;
		etu_div_d = etu_div_q;
		sticky_d = sticky_q | sticky_set;
		pready_d = psel && penable && !pready_q;
		pslverr_d = pready_d && !addr_hit(paddr);
		prdata_d = prdata_q;
		if (pready_d && !pwrite)
		begin
			unique case (paddr)
				OFS_GT_LOW: prdata_d = {24'h000000, gt_q[7:0]};
				OFS_GT_HIGH: prdata_d = {31'h00000000, gt_q[8]};
				OFS_SETUP: prdata_d = {31'h00000000, bge_q};
				OFS_CTRL: prdata_d = {30'h00000000, ctrl_q};
				OFS_CARD: prdata_d = {29'h00000000, card_sw_q};
				OFS_WT0: prdata_d = {24'h000000, wt_q[7:0]};
				OFS_WT1: prdata_d = {24'h000000, wt_q[15:8]};
				OFS_WT2: prdata_d = {24'h000000, wt_q[23:16]};
				OFS_WT3: prdata_d = {24'h000000, wt_q[31:24]};
				OFS_ETU_LOW: prdata_d = {24'h000000, etu_div_q[7:0]};
				OFS_ETU_HIGH: prdata_d = {29'h00000000, etu_div_q[10:8]};
				OFS_STATUS: prdata_d = {25'h0000000, sticky_q, card.rst,
					(da_q != DA_IDLE), present, locked_q};
				default: prdata_d = 32'h0000_0000;
			endcase
		end
		if (wr)
		begin
			unique case (paddr)
				OFS_GT_LOW: gt_d[7:0] = pwdata[7:0]; // see RULE_01
				OFS_GT_HIGH: gt_d[8] = pwdata[0];
				OFS_SETUP: bge_d = pwdata[SETUP_BGE];
				OFS_CTRL: ctrl_d = pwdata[1:0];
				OFS_CARD: card_sw_d = pwdata[2:0];
				OFS_WT0: wt_d[7:0] = pwdata[7:0];
				OFS_WT1: wt_d[15:8] = pwdata[7:0];
				OFS_WT2:
				begin
					wt_d[23:16] = pwdata[7:0];
					hold_d = {wt_q[31:24], pwdata[7:0], wt_q[15:0]}; // see RULE_08
				end
				OFS_WT3: wt_d[31:24] = pwdata[7:0];
				OFS_ETU_LOW: etu_div_d[7:0] = pwdata[7:0];
				OFS_ETU_HIGH: etu_div_d[10:8] = pwdata[2:0];
				OFS_STATUS: sticky_d = sticky_q & ~pwdata[6:4] | sticky_set;
				default: gt_d = gt_q;
			endcase
		end
	end

	// register storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gt_q <= GT_RST;
			bge_q <= 1'b0;
			ctrl_q <= 2'b00;
			card_sw_q <= 3'b000;
			wt_q <= WT_RST;
			hold_q <= WT_RST;
			etu_div_q <= ETU_RST;
			sticky_q <= 3'b000;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			gt_q <= gt_d;
			bge_q <= bge_d;
			ctrl_q <= ctrl_d;
			card_sw_q <= card_sw_d;
			wt_q <= wt_d;
			hold_q <= hold_d;
			etu_div_q <= etu_div_d;
			sticky_q <= sticky_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// etu tick and guard counters
	logic [10:0] etu_cnt_q, etu_cnt_d;
	logic etu_tick;
	logic [8:0] gcnt_q, gcnt_d;
	logic [8:0] bcnt_q, bcnt_d;
	logic [8:0] shadow_q, shadow_d;
	logic bge_prev_q;

	assign card_edge = s2_q[0] && !clk_prev_q && card.clk_en;
	assign etu_tick = card_edge && (etu_cnt_q + 11'h001 >= etu_div_q);

	// guard windows; the block guard is met again by each terminal start
	always_comb
	begin
		etu_cnt_d = etu_cnt_q;
		if (card_edge)
			etu_cnt_d = etu_tick ? 11'h000 : etu_cnt_q + 11'h001;
		gcnt_d = gcnt_q;
		if (shift.tx_start)
			gcnt_d = GT_START; // see RULE_21
		else if (etu_tick && gcnt_q < gt_q)
			gcnt_d = gcnt_q + 9'h001; // see RULE_21
		shadow_d = (bge_q && !bge_prev_q) ? gt_q : shadow_q; // see RULE_22
		bcnt_d = bcnt_q;
		if (shift.tx_start)
			bcnt_d = shadow_q;
		else if (shift.rx_start)
			bcnt_d = 9'h000;
		else if (etu_tick && bcnt_q < shadow_q)
			bcnt_d = bcnt_q + 9'h001;
	end

	// guard counter storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_prev_q <= 1'b0;
			etu_cnt_q <= 11'h000;
			gcnt_q <= GT_RST;
			bcnt_q <= GT_RST;
			shadow_q <= GT_RST;
			bge_prev_q <= 1'b0;
		end
		else
		begin
			clk_prev_q <= s2_q[0];
			etu_cnt_q <= etu_cnt_d;
			gcnt_q <= gcnt_d;
			bcnt_q <= bcnt_d;
			shadow_q <= shadow_d;
			bge_prev_q <= bge_q;
		end
	end

	// transmit only after the guard window (and the block window when bge_q is set), while unlocked and powered
	assign tx_permit = (gcnt_q >= gt_q) && (!bge_q || bcnt_q >= shadow_q) // see RULE_02
		&& !locked_q && card.rst && (da_q == DA_IDLE);
	assign rx_enable = !locked_q && card.rst && (da_q == DA_IDLE); // see RULE_05

	////////////////////////////////////////////////////////////////////////////////
	// waiting-time counter
	logic [31:0] wcnt_q, wcnt_d;
	logic run_q, run_d;
	logic locked_d;
	logic wait_timer_enable_prev_q;
	logic to_d, to_q;
	logic wait_timer_enable;
	logic auto_mode;
	assign wait_timer_enable = ctrl_q[CTRL_WAIT_TIMER_ENABLE];
	assign auto_mode = ctrl_q[CTRL_UART] && wait_timer_enable; // see RULE_06
	assign wt_timeout = to_q;

	// load, count down and lock on expiry
	always_comb
	begin
		wcnt_d = wcnt_q;
		run_d = run_q;
		locked_d = locked_q;
		to_d = 1'b0;
		if (wait_timer_enable && !wait_timer_enable_prev_q)
		begin
			wcnt_d = hold_q; // see RULE_07
			run_d = 1'b1;
			locked_d = 1'b0;
		end
		else if (!wait_timer_enable && wait_timer_enable_prev_q)
			run_d = 1'b0; // see RULE_07
		else if (auto_mode && !locked_q && (shift.rx_start || shift.tx_start))
		begin
			wcnt_d = hold_q; // see RULE_11
			run_d = 1'b1;
		end
		else if (run_q && etu_tick)
		begin
			if (wcnt_q == 32'h0000_0000)
			begin
				run_d = 1'b0; // see RULE_12
				locked_d = 1'b1; // see RULE_05
				to_d = 1'b1;
			end
			else
				wcnt_d = wcnt_q - 32'h0000_0001; // see RULE_04
		end
	end

	// waiting-time storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wcnt_q <= WT_RST;
			run_q <= 1'b0;
			locked_q <= 1'b0;
			wait_timer_enable_prev_q <= 1'b0;
			to_q <= 1'b0;
		end
		else
		begin
			wcnt_q <= wcnt_d;
			run_q <= run_d;
			locked_q <= locked_d;
			wait_timer_enable_prev_q <= wait_timer_enable;
			to_q <= to_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// activation, reset timing and automatic deactivation
	sct_deact_type da_d;
	logic [4:0] step_q, step_d;
	sct_pins_type card_q, card_d;
	logic [15:0] rst_low_d, atr_cnt_d;
	logic warm_q, warm_d;
	logic atr_wait_q, atr_wait_d;
	logic idle;
	assign idle = (da_q == DA_IDLE);
	assign card = card_q;

	// pin levels, deactivation steps and clock window counters
	always_comb
	begin
		da_d = da_q;
		step_d = (step_q == 5'(DEACT_STEP_CYC - 1)) ? 5'h00 : step_q + 5'h01;
		unique case (da_q)
			DA_IDLE:
			begin
				step_d = 5'h00;
				if (card_q.vcc_en && (!present || power_lost))
					da_d = DA_RST; // see RULE_20
			end
			DA_RST: if (step_q == 5'(DEACT_STEP_CYC - 1)) da_d = DA_CLK;
			DA_CLK: if (step_q == 5'(DEACT_STEP_CYC - 1)) da_d = DA_IO;
			DA_IO: if (step_q == 5'(DEACT_STEP_CYC - 1)) da_d = DA_VCC;
			DA_VCC:
			begin
				step_d = 5'h00;
				if (!card_sw_q[CARD_VCC])
					da_d = DA_IDLE;
			end
			default: da_d = DA_VCC;
		endcase
		card_d.vcc_en = card_sw_q[CARD_VCC] && (idle ? (card_q.vcc_en || (present // see RULE_17
			&& !power_lost)) : (da_q != DA_VCC));
		// clock starts a cycle after supply and never outlives it
		card_d.clk_en = card_sw_q[CARD_CLK] && card_q.vcc_en && card_d.vcc_en
			&& (idle || da_q == DA_RST); // see RULE_18
		// reset rises only once the clock runs, so supply, clock, reset come in order
		card_d.rst = 1'b0; // see RULE_18
		if (idle && card_sw_q[CARD_RST])
			card_d.rst = card_q.clk_en && (card_q.rst || !warm_q // see RULE_18
				|| (rst_low_q > WARM_RST_MIN_CLK)); // see RULE_19
		// io stays receiving in the cycle in which reset falls
		card_d.io_out = idle && card_q.rst && card_d.rst && shift.tx_bit;
		card_d.io_oe_n = !((da_q == DA_IO) || (da_q == DA_VCC)
			|| (idle && card_q.rst && card_d.rst && shift.tx_active && !locked_q));
		rst_low_d = 16'h0000;
		if (!card_q.rst)
			rst_low_d = (card_edge && rst_low_q != 16'hFFFF) ? rst_low_q + 16'h0001 : rst_low_q;
		warm_d = card_q.vcc_en && (card_q.rst ? card_q.clk_en : warm_q);
		atr_wait_d = atr_wait_q && card_q.rst;
		atr_cnt_d = atr_cnt_q;
		sticky_set = 3'b000;
		sticky_set[0] = to_q;
		if (card_q.rst && !card_d.rst)
			atr_wait_d = 1'b0;
		else if (!card_q.rst && card_d.rst)
		begin
			atr_wait_d = 1'b1;
			atr_cnt_d = 16'h0000;
		end
		else if (atr_wait_q && shift.rx_start)
		begin
			atr_wait_d = 1'b0;
			sticky_set[2] = atr_cnt_q < ATR_MIN_CLK; // see RULE_18
		end
		else if (atr_wait_q && card_edge)
		begin
			atr_cnt_d = atr_cnt_q + 16'h0001;
			if (atr_cnt_d >= ATR_MAX_CLK)
			begin
				atr_wait_d = 1'b0;
				sticky_set[1] = 1'b1; // see RULE_18
			end
		end
	end

	// activation storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			da_q <= DA_IDLE;
			step_q <= 5'h00;
			card_q <= '{vcc_en: 1'b0, clk_en: 1'b0, rst: 1'b0, io_out: 1'b0, io_oe_n: 1'b1};
			rst_low_q <= 16'h0000;
			atr_cnt_q <= 16'h0000;
			warm_q <= 1'b0;
			atr_wait_q <= 1'b0;
		end
		else
		begin
			da_q <= da_d;
			step_q <= step_d;
			card_q <= card_d;
			rst_low_q <= rst_low_d;
			atr_cnt_q <= atr_cnt_d;
			warm_q <= warm_d;
			atr_wait_q <= atr_wait_d;
		end
	end

endmodule

// ==== sct_pkg.sv ====
// Purpose: shared constants, states and carriers of the card timing block
// Assumes: 25 MHz pclk, APB register access with 32-bit data
// Notes: all offsets are byte addresses of aligned words
package sct_pkg;

	// clock and derived cycle counts
	localparam int unsigned CLK_NS = 40;
	localparam int unsigned DEACT_STEP_NS = 1000;
	localparam int unsigned DEACT_STEP_CYC = (DEACT_STEP_NS + CLK_NS - 1) / CLK_NS;

	// card clock counts for reset and answer-to-reset windows
	localparam logic [15:0] WARM_RST_MIN_CLK = 16'h0190;
	localparam logic [15:0] ATR_MIN_CLK = 16'h0190;
	localparam logic [15:0] ATR_MAX_CLK = 16'h9C40;

	// register offsets
	localparam logic [7:0] OFS_GT_LOW = 8'h00;
	localparam logic [7:0] OFS_GT_HIGH = 8'h04;
	localparam logic [7:0] OFS_SETUP = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0C;
	localparam logic [7:0] OFS_CARD = 8'h10;
	localparam logic [7:0] OFS_WT0 = 8'h14;
	localparam logic [7:0] OFS_WT1 = 8'h18;
	localparam logic [7:0] OFS_WT2 = 8'h1C;
	localparam logic [7:0] OFS_WT3 = 8'h20;
	localparam logic [7:0] OFS_ETU_LOW = 8'h24;
	localparam logic [7:0] OFS_ETU_HIGH = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2C;

	// field positions
	localparam int unsigned SETUP_BGE = 0;
	localparam int unsigned CTRL_WAIT_TIMER_ENABLE = 0;
	localparam int unsigned CTRL_UART = 1;
	localparam int unsigned CARD_VCC = 0;
	localparam int unsigned CARD_CLK = 1;
	localparam int unsigned CARD_RST = 2;
	localparam int unsigned ST_LOCKED = 0;
	localparam int unsigned ST_PRESENT = 1;
	localparam int unsigned ST_DEACT = 2;
	localparam int unsigned ST_RST = 3;
	localparam int unsigned ST_TIMEOUT = 4;
	localparam int unsigned ST_ATR_LATE = 5;
	localparam int unsigned ST_ATR_EARLY = 6;

	// reset and start values
	localparam logic [8:0] GT_RST = 9'h000;
	localparam logic [8:0] GT_START = 9'h001;
	localparam logic [10:0] ETU_RST = 11'h174;
	localparam logic [31:0] WT_RST = 32'h0000_0000;

	// automatic deactivation steps, gray coded along the path
	typedef enum logic [2:0] {
		DA_IDLE = 3'b000,
		DA_RST = 3'b001,
		DA_CLK = 3'b011,
		DA_IO = 3'b010,
		DA_VCC = 3'b110
	} sct_deact_type;

	// events from the character shifter
	typedef struct packed {
		logic tx_start;
		logic rx_start;
		logic tx_active;
		logic tx_bit;
	} sct_shift_type;

	// signals toward the card contacts
	typedef struct packed {
		logic vcc_en;
		logic clk_en;
		logic rst;
		logic io_out;
		logic io_oe_n;
	} sct_pins_type;

endpackage

// ==== sct_core_assertions.sv ====
// Purpose: port checks of the card timing block
// Assumes: one pclk domain, presetn async active low
// Notes: bound to every sct_core
`timescale 1ns/1ps
////////////////////////////////////////
module sct_checker
	import sct_pkg::*;
(
	// clock, reset, apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// card side
	input wire logic card_present,
	input wire logic tx_permit,
	input wire logic rx_enable,
	input wire logic wt_timeout,
	input wire sct_pkg::sct_pins_type card
);
	// all checks on pclk, off in reset
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// one wait cycle per access
	property p_apb_wait;
		psel && $rose(penable) |-> !pready ##1 pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb wait wrong");
	// expiry locks at once
	property p_lock;
		wt_timeout |-> !rx_enable && !tx_permit;
	endproperty
	a_lock: assert property (p_lock) else $error("no lock on expiry");
	// expiry is a single pulse
	property p_pulse;
		wt_timeout |=> !wt_timeout;
	endproperty
	a_pulse: assert property (p_pulse) else $error("expiry too long");
	// no supply without a card
	property p_need_card;
		!card_present [*4] |-> !$rose(card.vcc_en);
	endproperty
	a_need_card: assert property (p_need_card) else $error("supply w/o card");
	// clock only with supply
	property p_clk_vcc;
		card.clk_en |-> card.vcc_en;
	endproperty
	a_clk_vcc: assert property (p_clk_vcc) else $error("clock w/o supply");
	// io receives while reset is low and the clock runs
	property p_io_rx;
		!card.rst && card.clk_en |-> card.io_oe_n;
	endproperty
	a_io_rx: assert property (p_io_rx) else $error("io driven in reset");
	// no traffic while card held in reset
	property p_quiet;
		!card.rst |-> !tx_permit && !rx_enable;
	endproperty
	a_quiet: assert property (p_quiet) else $error("traffic in reset");
	// warm reset stays low
	property p_warm;
		$fell(card.rst) && card.clk_en |=> !card.rst [*8];
	endproperty
	a_warm: assert property (p_warm) else $error("warm reset short");
	// supply drops last on extraction
	property p_deact;
		$fell(card.vcc_en) && !card_present |-> !card.clk_en && !card.rst;
	endproperty
	a_deact: assert property (p_deact) else $error("deactivation order");
endmodule
bind sct_core sct_checker i_sct_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .card_present(card_present), .tx_permit(tx_permit),
	.rx_enable(rx_enable), .wt_timeout(wt_timeout), .card(card));

// ==== sct_card_model.sv ====
// Purpose: card model on the io line
// Assumes: io line pulled up, card clock gated by clk_en
// Notes: answers each reset with one start bit
`timescale 1ns/1ps
////////////////////////////////////////
module sct_card_model
	import sct_pkg::*;
#(
	parameter int unsigned ATR_DELAY = 500
)
(
	// terminal side
	input wire logic card_clk_in,
	input wire sct_pkg::sct_pins_type card,
	input wire logic inserted,
	// back to terminal
	output logic io_in,
	output logic card_present
);
	logic atr_low = 1'b0;
	int unsigned cnt = 0;
	// presence switch
	assign card_present = inserted;
	// pulled-up line, either side pulls low
	assign io_in = (card.io_oe_n | card.io_out) & ~atr_low;
	// start bit a fixed time after reset rises
	always @(posedge card_clk_in)
	begin
		if (!card.rst || !card.clk_en)
		begin
			cnt <= 0;
			atr_low <= 1'b0;
		end
		else if (cnt < ATR_DELAY + 372)
		begin
			cnt <= cnt + 1;
			atr_low <= (cnt >= ATR_DELAY);
		end
		else
			atr_low <= 1'b0;
	end
endmodule

// ==== tb.sv ====
// Purpose: self-checking bench of the card timing block
// Assumes: card clock 320 ns, etu divider set to one
// Notes: one card clock edge is one etu
`timescale 1ns/1ps
`define CHK(a, e) chk_val(32'(a), 32'(e))
////////////////////////////////////////
module tb;
	import sct_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic lclk = 1'b0;
	logic inserted = 1'b1;
	logic supply_fail = 1'b0;
	logic io_in;
	logic card_present;
	sct_shift_type shift = 4'h0;
	logic tx_permit;
	logic rx_enable;
	logic rx_io;
	logic wt_timeout;
	sct_pins_type card;
	int fail_count = 0;
	int samples_checked = 0;
	int n;
	logic [31:0] d;
	logic err;
	// bus clock and card clock
	always #20 pclk = ~pclk;
	always #160 lclk = ~lclk;
	sct_core i_sct_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .card_clk_in(lclk), .card_present(card_present),
		.supply_fail(supply_fail), .io_in(io_in), .shift(shift), .tx_permit(tx_permit),
		.rx_enable(rx_enable), .rx_io(rx_io), .wt_timeout(wt_timeout), .card(card));
	sct_card_model i_sct_card_model (.card_clk_in(lclk), .card(card), .inserted(inserted),
		.io_in(io_in), .card_present(card_present));
	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// compare and count
	task automatic chk_val(input logic [31:0] a, input logic [31:0] e);
		samples_checked++;
		if (a !== e)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, a, e);
		end
	endtask
	// one apb transfer, answer in d and err
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= w;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 16 && pready !== 1'b1; k++)
			@(posedge pclk);
		if (pready !== 1'b1)
		begin
			fail_count++;
			results();
		end
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// settle just after a card clock edge
	task automatic align(input int c);
		@(posedge lclk);
		repeat (c) @(posedge pclk);
	endtask
	// one start event from the shifter
	task automatic pulse(input logic tx);
		shift.tx_start <= tx;
		shift.rx_start <= ~tx;
		@(posedge pclk);
		shift <= 4'h0;
	endtask
	// count card clock edges until permit, expiry or reset high
	task automatic count(input int sel);
		int k;
		logic prev;
		prev = lclk;
		n = 0;
		for (k = 0; k < 8000; k++)
		begin
			@(posedge pclk);
			if (sel == 0 ? tx_permit === 1'b1 : sel == 1 ? wt_timeout === 1'b1 : card.rst === 1'b1)
				break;
			if (lclk && !prev)
				n++;
			prev = lclk;
		end
		if (k == 8000)
		begin
			fail_count++;
			results();
		end
	endtask
	// main sequence
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFS_ETU_LOW, 32'h0);
		`CHK(d, ETU_RST[7:0]);
		apb(1'b0, 8'h30, 32'h0);
		`CHK(err, 1'b1);
		`CHK(d, 32'h0);
		apb(1'b1, OFS_ETU_LOW, 32'h1);
		apb(1'b1, OFS_ETU_HIGH, 32'h0);
		apb(1'b1, OFS_CARD, 32'h7);
		apb(1'b1, OFS_GT_HIGH, 32'h0);
		apb(1'b1, OFS_GT_LOW, 32'h16);
		apb(1'b1, OFS_SETUP, 32'h1);
		apb(1'b1, OFS_GT_LOW, 32'hC);
		align(5);
		pulse(1'b1);
		count(0);
		`CHK(n, 11);
		align(5);
		pulse(1'b0);
		count(0);
		`CHK(n, 22);
		// etu 1 to 3: block guard reloaded with (22 + 11) * 1 / 3 + 22
		apb(1'b1, OFS_ETU_LOW, 32'h3);
		apb(1'b1, OFS_SETUP, 32'h0);
		apb(1'b1, OFS_GT_LOW, 32'h21);
		apb(1'b1, OFS_SETUP, 32'h1);
		align(5);
		pulse(1'b0);
		count(0);
		`CHK(n >= 97 && n <= 99, 1'b1);
		// back to the normal etu and guard values
		apb(1'b1, OFS_ETU_LOW, 32'h1);
		apb(1'b1, OFS_SETUP, 32'h0);
		apb(1'b1, OFS_GT_LOW, 32'h16);
		apb(1'b1, OFS_SETUP, 32'h1);
		apb(1'b1, OFS_GT_LOW, 32'hC);
		$display("guard done");
		apb(1'b1, OFS_WT0, 32'h2);
		apb(1'b1, OFS_WT1, 32'h1);
		apb(1'b1, OFS_WT3, 32'h0);
		apb(1'b1, OFS_WT2, 32'h0);
		align(3);
		apb(1'b1, OFS_CTRL, 32'h1);
		count(1);
		`CHK(n, 259);
		`CHK(rx_enable, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK(d & 32'h11, 32'h11);
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_WT2, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h1);
		@(posedge pclk);
		`CHK(rx_enable, 1'b1);
		apb(1'b1, OFS_STATUS, 32'h10);
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (300) @(posedge lclk);
		@(posedge pclk);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK(d & 32'h11, 32'h0);
		$display("manual done");
		apb(1'b1, OFS_WT0, 32'h5);
		apb(1'b1, OFS_WT1, 32'h0);
		apb(1'b1, OFS_WT2, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (6)
		begin
			align(5);
			pulse(1'b0);
			repeat (3) @(posedge lclk);
		end
		@(posedge pclk);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK(d & 32'h11, 32'h0);
		// a new hold value takes effect at the next terminal start
		apb(1'b1, OFS_WT0, 32'h7);
		apb(1'b1, OFS_WT2, 32'h0);
		align(5);
		pulse(1'b1);
		count(1);
		`CHK(n, 8);
		$display("auto done");
		apb(1'b1, OFS_STATUS, 32'h70);
		apb(1'b1, OFS_CARD, 32'h3);
		apb(1'b1, OFS_CARD, 32'h7);
		count(2);
		`CHK(n >= 400 && n < 405, 1'b1);
		pulse(1'b0);
		repeat (600) @(posedge lclk);
		@(posedge pclk);
		`CHK(rx_io, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK(d & 32'h68, 32'h48);
		inserted <= 1'b0;
		repeat (120) @(posedge pclk);
		`CHK(card, 5'h00);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK(d & 32'h6, 32'h4);
		apb(1'b1, OFS_CARD, 32'h0);
		apb(1'b1, OFS_CARD, 32'h1);
		`CHK(card.vcc_en, 1'b0);
		inserted <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK(card.vcc_en, 1'b1);
		supply_fail <= 1'b1;
		repeat (120) @(posedge pclk);
		`CHK(card.vcc_en, 1'b0);
		$display("card done");
		results();
	end
endmodule
